// ==== design/scs_supervisor.sv ====
// supply control and fault supervisor: pin control, restart lockout, fault
// shutdown and retry, open-drain monitor lines, status register port
// assumes all inputs synchronous to clk_sys; pads resolve open-drain enables
`timescale 1ns/10ps
module scs_supervisor #(
    parameter int SAMPLE_CYCLES = scs_pkg::SAMPLE_CYCLES,
    parameter int RETRY_TICKS = scs_pkg::RETRY_TICKS,
    parameter int CRANK_DIP_TICKS = scs_pkg::CRANK_DIP_TICKS,
    parameter int CRANK_FULL_TICKS = scs_pkg::CRANK_FULL_TICKS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // backplane control pins
    input wire logic enable_n,
    input wire logic inhibit_n,
    input wire logic slot_addr_bit0_n,
    input wire logic slot_addr_bit1_n,
    input wire logic slot_addr_bit2_n,
    input wire logic slot_addr_bit3_n,
    input wire logic slot_addr_bit4_n,
    input wire logic slot_addr_parity_n,
    // supply monitors
    input wire logic [1:0] input_range_guard,
    input wire logic [4:0] output_overvolt_guard,
    input wire logic [4:0] output_overcurrent_guard,
    input wire logic starter_engage_dip,
    input wire logic crank_low_input,
    input wire logic [7:0] temp_sensor_a,
    input wire logic [7:0] temp_sensor_b,
    input wire logic [15:0] edge_temp_p0,
    input wire logic [15:0] edge_temp_p1,
    // register port
    input wire logic [scs_pkg::REG_AW-1:0] reg_addr,
    input wire logic [scs_pkg::REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [scs_pkg::REG_DW-1:0] reg_rdata,
    // rail enables
    output logic main_12v_rail_en,
    output logic main_5v_rail_en,
    output logic aux_3v3_rail_en,
    output logic aux_12v_rail_en,
    output logic aux_neg12v_rail_en,
    output logic power_limit_500w,
    // open-drain monitors
    output logic fail_o,
    output logic fail_oe,
    output logic system_hold_o,
    output logic system_hold_oe,
    // management ports
    output logic [6:0] mgmt_addr,
    output logic mgmt_ports_en
);
    import scs_pkg::*;

    typedef struct packed {
        scs_state_type state;
        logic [15:0] sample_cnt;
        logic tick;
        logic [9:0] pu_cnt;
        logic capture;
        logic [2:0] range_cnt;
        logic all_on;
        logic aux_only;
        logic [4:0] lockout_cnt;
        logic prot_fault;
        logic [15:0] retry_cnt;
        logic over_temp;
        logic [7:0] hot_temp;
        logic [19:0] crank_cnt;
        logic [15:0] dip_cnt;
        logic crank_shut;
        logic limit_500w;
        logic [7:0] status;
        logic [15:0] rdata;
        logic [4:0] rails;
        logic fail_drv;
        logic hold_drv;
        logic ports_en;
    } scs_sup_type;

    scs_sup_type sup_reg;
    scs_sup_type sup_next;
    logic [1:0] pin_raw;
    logic [1:0] pin_db;
    logic en_act;
    logic inh_act;
    logic want_all;
    logic want_aux;
    logic prot_now;
    logic in_range;
    logic fault_event;
    logic shut_ok;
    logic [7:0] hot_now;

    assign pin_raw = {inhibit_n, enable_n};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_deb
            scs_debounce u_deb (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .tick(sup_reg.tick),
                .pin_raw(pin_raw[gi]),
                .pin_stable(pin_db[gi])
            );
        end
    endgenerate

    scs_addr_capture u_addr (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .slot_addr_n({slot_addr_bit4_n, slot_addr_bit3_n, slot_addr_bit2_n,
                      slot_addr_bit1_n, slot_addr_bit0_n}),
        .slot_addr_parity_n(slot_addr_parity_n),
        .capture(sup_reg.capture),
        .mgmt_addr(mgmt_addr)
    );

    always_comb begin
        sup_next = sup_reg;
        sup_next.tick = 1'b0;
        sup_next.capture = 1'b0;

        // sample tick divider
        if (sup_reg.sample_cnt == 16'(SAMPLE_CYCLES - 1)) begin
            sup_next.sample_cnt = 16'h0000;
            sup_next.tick = 1'b1;
        end else begin
            sup_next.sample_cnt = sup_reg.sample_cnt + 16'h0001;
        end

        // control source selection, active-low pins
        if (sup_reg.status[STAT_SOFTWARE_OVERRIDE_BIT]) begin
            en_act = ~sup_reg.status[STAT_SW_ENABLE_N];
            inh_act = ~sup_reg.status[STAT_SW_INHIBIT_N];
        end else begin
            en_act = ~pin_db[0];
            inh_act = ~pin_db[1];
        end
        want_all = en_act & ~inh_act;
        want_aux = en_act & inh_act;

        in_range = (input_range_guard == 2'b00);
        prot_now = (|output_overvolt_guard) | (|output_overcurrent_guard);
        hot_now = (temp_sensor_a > temp_sensor_b) ? temp_sensor_a : temp_sensor_b;
        shut_ok = ~sup_reg.status[STAT_SAFETY_OVERRIDE];
        fault_event = 1'b0;

        // sampled evaluation of supply conditions
        if (sup_reg.tick) begin
            sup_next.hot_temp = hot_now;
            if (!in_range) begin
                if (sup_reg.range_cnt != 3'(INPUT_FAULT_TICKS)) begin
                    sup_next.range_cnt = sup_reg.range_cnt + 3'h1;
                end
            end else begin
                sup_next.range_cnt = 3'h0;
            end
            // overvoltage and overcurrent: off now, retry on 1 s steps
            if (!sup_reg.prot_fault) begin
                if (prot_now && shut_ok) begin
                    sup_next.prot_fault = 1'b1;
                    sup_next.retry_cnt = 16'h0000;
                    fault_event = 1'b1;
                end
            end else if (sup_reg.retry_cnt == 16'(RETRY_TICKS - 1)) begin
                sup_next.retry_cnt = 16'h0000;
                if (!prot_now) begin
                    sup_next.prot_fault = 1'b0;
                end
            end else begin
                sup_next.retry_cnt = sup_reg.retry_cnt + 16'h0001;
            end
            // over-temperature with hysteresis
            if (!sup_reg.over_temp && hot_now >= TEMP_TRIP_C && shut_ok) begin
                sup_next.over_temp = 1'b1;
                fault_event = 1'b1;
            end else if (sup_reg.over_temp && hot_now <= TEMP_RESUME_C) begin
                sup_next.over_temp = 1'b0;
            end
            // starter dip and cranking duration
            if (starter_engage_dip) begin
                if (sup_reg.dip_cnt != 16'(CRANK_DIP_TICKS)) begin
                    sup_next.dip_cnt = sup_reg.dip_cnt + 16'h0001;
                end
            end else begin
                sup_next.dip_cnt = 16'h0000;
            end
            if (crank_low_input) begin
                if (sup_reg.crank_cnt != 20'(CRANK_FULL_TICKS)) begin
                    sup_next.crank_cnt = sup_reg.crank_cnt + 20'h00001;
                end
            end else begin
                sup_next.crank_cnt = 20'h00000;
            end
            sup_next.limit_500w = starter_engage_dip &&
                (sup_reg.dip_cnt != 16'(CRANK_DIP_TICKS));
            sup_next.crank_shut = (starter_engage_dip &&
                sup_reg.dip_cnt == 16'(CRANK_DIP_TICKS)) ||
                (crank_low_input && sup_reg.crank_cnt == 20'(CRANK_FULL_TICKS));
            if (!sup_reg.crank_shut && sup_next.crank_shut) begin
                fault_event = 1'b1;
            end
            // lockout countdown between control changes
            if (sup_reg.lockout_cnt != 5'h00) begin
                sup_next.lockout_cnt = sup_reg.lockout_cnt - 5'h01;
            end
        end

        // apply the requested control state only outside lockout
        if (sup_reg.lockout_cnt == 5'h00 &&
            (want_all != sup_reg.all_on || want_aux != sup_reg.aux_only)) begin
            sup_next.all_on = want_all;
            sup_next.aux_only = want_aux;
            sup_next.lockout_cnt = 5'(LOCKOUT_TICKS);
        end

        // register writes; bits 1:0 mirror the filtered pins, except one cycle after a fault return loads STATUS_RESET
        if (reg_wr && reg_addr == REG_STATUS && sup_reg.ports_en) begin
            sup_next.status = (reg_wdata[7:0] & STATUS_WR_MASK) |
                              (sup_reg.status & ~STATUS_WR_MASK);
        end
        // hardware clears win over a manager set in the same cycle
        if (fault_event) begin
            sup_next.status[STAT_FAIL] = 1'b0;
        end
        if (sup_reg.tick && hot_now >= TEMP_WARN_C) begin
            sup_next.status[STAT_TEMP_WARN] = 1'b0;
        end
        sup_next.status[STAT_HW_INHIBIT_N] = pin_db[1];
        sup_next.status[STAT_HW_ENABLE_N] = pin_db[0];

        // supervisor sequence
        case (sup_reg.state)
            ST_POWERUP: begin
                if (sup_reg.tick) begin
                    sup_next.pu_cnt = sup_reg.pu_cnt + 10'h001;
                    if (sup_reg.pu_cnt == 10'(DEBOUNCE_TICKS)) begin
                        sup_next.capture = 1'b1;
                    end
                    if (sup_reg.pu_cnt == 10'(POWERUP_TICKS - 1)) begin
                        sup_next.state = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (sup_reg.range_cnt == 3'(INPUT_FAULT_TICKS)) begin
                    sup_next.state = ST_INPUT_FAULT;
                end
            end
            default: begin
                // returns through a fresh power-up, as after a power cycle
                if (sup_reg.tick && in_range) begin
                    sup_next.state = ST_POWERUP;
                    sup_next.pu_cnt = 10'h000;
                    sup_next.range_cnt = 3'h0;
                    sup_next.status = STATUS_RESET;
                    sup_next.all_on = 1'b0;
                    sup_next.aux_only = 1'b0;
                end
            end
        endcase

        // outputs
        if (sup_next.state == ST_RUN && !sup_next.prot_fault &&
            !sup_next.over_temp && !sup_next.crank_shut) begin
            sup_next.rails = {sup_next.all_on, sup_next.all_on,
                              sup_next.all_on | sup_next.aux_only,
                              sup_next.all_on, sup_next.all_on};
        end else begin
            sup_next.rails = 5'h00;
        end
        sup_next.hold_drv = (sup_next.state != ST_RUN);
        sup_next.fail_drv = sup_next.hold_drv || sup_next.prot_fault ||
                            sup_next.over_temp || sup_next.crank_shut;
        sup_next.ports_en = (sup_next.state != ST_INPUT_FAULT);

        // read data valid in the cycle after the strobe only
        sup_next.rdata = 16'h0000;
        if (reg_rd) begin
            if (reg_addr == REG_STATUS) begin
                sup_next.rdata = {8'h00, sup_reg.status};
            end else if (reg_addr == REG_HW_ADDR) begin
                sup_next.rdata = {9'h000, mgmt_addr};
            end else if (reg_addr == REG_HOT_TEMP) begin
                sup_next.rdata = {8'h00, sup_reg.hot_temp};
            end else if (reg_addr == REG_EDGE_P0) begin
                sup_next.rdata = edge_temp_p0;
            end else if (reg_addr == REG_EDGE_P1) begin
                sup_next.rdata = edge_temp_p1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sup_reg <= '0;
            sup_reg.state <= ST_POWERUP;
            sup_reg.status <= STATUS_RESET | 8'h03;
            sup_reg.fail_drv <= 1'b1;
            sup_reg.hold_drv <= 1'b1;
            sup_reg.ports_en <= 1'b1;
        end else begin
            sup_reg <= sup_next;
        end
    end

    assign reg_rdata = sup_reg.rdata;
    assign main_12v_rail_en = sup_reg.rails[4];
    assign main_5v_rail_en = sup_reg.rails[3];
    assign aux_3v3_rail_en = sup_reg.rails[2];
    assign aux_12v_rail_en = sup_reg.rails[1];
    assign aux_neg12v_rail_en = sup_reg.rails[0];
    assign power_limit_500w = sup_reg.limit_500w;
    assign fail_o = 1'b0 & sup_reg.fail_drv;
    assign fail_oe = sup_reg.fail_drv;
    assign system_hold_o = 1'b0 & sup_reg.hold_drv;
    assign system_hold_oe = sup_reg.hold_drv;
    assign mgmt_ports_en = sup_reg.ports_en;

endmodule

// ==== design/scs_pkg.sv ====
// constants, register map and state encoding of the supply control supervisor
// assumes a single 50 MHz system clock and a sample tick derived from it
package scs_pkg;

    // time base
    localparam int CLK_HZ = 50_000_000;
    localparam int SAMPLE_PERIOD_US = 200;
    localparam int SAMPLE_CYCLES = CLK_HZ / 1_000_000 * SAMPLE_PERIOD_US;

    // fault and control timing, figures in ms, counts in sample ticks
    localparam int DEBOUNCE_MS = 5;
    localparam int DEBOUNCE_TICKS = (DEBOUNCE_MS * 1000 + SAMPLE_PERIOD_US - 1) / SAMPLE_PERIOD_US;
    localparam int LOCKOUT_MS = 5;
    localparam int LOCKOUT_TICKS = (LOCKOUT_MS * 1000 + SAMPLE_PERIOD_US - 1) / SAMPLE_PERIOD_US;
    localparam int INPUT_FAULT_MS = 1;
    localparam int INPUT_FAULT_TICKS =
        (INPUT_FAULT_MS * 1000 + SAMPLE_PERIOD_US - 1) / SAMPLE_PERIOD_US;
    localparam int POWERUP_MS = 100;
    localparam int POWERUP_TICKS = (POWERUP_MS * 1000 + SAMPLE_PERIOD_US - 1) / SAMPLE_PERIOD_US;
    localparam int RETRY_MS = 1000;
    localparam int RETRY_TICKS = RETRY_MS * 1000 / SAMPLE_PERIOD_US;
    localparam int CRANK_DIP_MS = 1000;
    localparam int CRANK_DIP_TICKS = CRANK_DIP_MS * 1000 / SAMPLE_PERIOD_US;
    localparam int CRANK_FULL_MS = 30000;
    localparam int CRANK_FULL_TICKS = CRANK_FULL_MS * 1000 / SAMPLE_PERIOD_US;

    // temperature thresholds in degrees C
    localparam logic [7:0] TEMP_TRIP_C = 8'h5F;
    localparam logic [7:0] TEMP_HYST_C = 8'h14;
    localparam logic [7:0] TEMP_RESUME_C = TEMP_TRIP_C - TEMP_HYST_C;
    localparam logic [7:0] TEMP_WARN_C = 8'h55;

    // management address
    localparam logic [6:0] ADDR_BASE = 7'h20;

    // register port
    localparam int REG_AW = 4;
    localparam int REG_DW = 16;
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_HW_ADDR = 4'h1;
    localparam logic [3:0] REG_HOT_TEMP = 4'h2;
    localparam logic [3:0] REG_EDGE_P0 = 4'h3;
    localparam logic [3:0] REG_EDGE_P1 = 4'h4;

    // status byte fields
    localparam int STAT_SAFETY_OVERRIDE = 7;
    localparam int STAT_FAIL = 6;
    localparam int STAT_TEMP_WARN = 5;
    localparam int STAT_SOFTWARE_OVERRIDE_BIT = 4;
    localparam int STAT_SW_INHIBIT_N = 3;
    localparam int STAT_SW_ENABLE_N = 2;
    localparam int STAT_HW_INHIBIT_N = 1;
    localparam int STAT_HW_ENABLE_N = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] STATUS_WR_MASK = 8'hFC;

    typedef enum logic [1:0] {
        ST_POWERUP,
        ST_RUN,
        ST_INPUT_FAULT
    } scs_state_type;

endpackage

// ==== design/scs_debounce.sv ====
// debounce filter for one active-low control pin
// assumes the pin is synchronous to clk_sys and tick is a one-cycle pulse
`timescale 1ns/10ps
module scs_debounce (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // sampling
    input wire logic tick,
    input wire logic pin_raw,
    // filtered level
    output logic pin_stable
);
    import scs_pkg::*;

    typedef struct packed {
        logic stable;
        logic [4:0] cnt;
    } scs_deb_type;

    scs_deb_type deb_reg;
    scs_deb_type deb_next;

    always_comb begin
        deb_next = deb_reg;
        // a level change must persist a full delay before it is taken
        if (pin_raw == deb_reg.stable) begin
            deb_next.cnt = 5'h00;
        end else if (tick) begin
            if (deb_reg.cnt == 5'(DEBOUNCE_TICKS - 1)) begin
                deb_next.stable = pin_raw;
                deb_next.cnt = 5'h00;
            end else begin
                deb_next.cnt = deb_reg.cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            deb_reg <= '{stable: 1'b1, cnt: 5'h00};
        end else begin
            deb_reg <= deb_next;
        end
    end

    assign pin_stable = deb_reg.stable;

endmodule

// ==== design/scs_addr_capture.sv ====
// geographical slot address capture with odd parity check
// assumes capture is pulsed once per power-up by the supervisor
`timescale 1ns/10ps
module scs_addr_capture (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // slot pins, active low
    input wire logic [4:0] slot_addr_n,
    input wire logic slot_addr_parity_n,
    input wire logic capture,
    // captured address
    output logic [6:0] mgmt_addr
);
    import scs_pkg::*;

    typedef struct packed {
        logic [6:0] addr;
    } scs_addr_type;

    scs_addr_type addr_reg;
    scs_addr_type addr_next;
    logic [4:0] grounded;
    logic parity_ok;

    always_comb begin
        grounded = ~slot_addr_n;
        // grounded pins including parity must count odd
        parity_ok = ^{grounded, ~slot_addr_parity_n};
        addr_next = addr_reg;
        if (capture) begin
            if (parity_ok) begin
                addr_next.addr = ADDR_BASE + {2'b00, grounded};
            end else begin
                addr_next.addr = ADDR_BASE;
            end
        end
    end

    // held until the next power-up capture
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            addr_reg <= '{addr: ADDR_BASE};
        end else begin
            addr_reg <= addr_next;
        end
    end

    assign mgmt_addr = addr_reg.addr;

endmodule

// ==== tb/scs_chk.sv ====
// concurrent checks on the supply supervisor top ports
// assumes binding onto scs_supervisor, clocked by clk_sys
`timescale 1ns/10ps
module scs_chk #(
    parameter int SAMPLE_CYCLES = 20
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // monitors
    input wire logic [1:0] input_range_guard,
    input wire logic [4:0] output_overvolt_guard,
    input wire logic [4:0] output_overcurrent_guard,
    input wire logic [7:0] temp_sensor_a,
    input wire logic [7:0] temp_sensor_b,
    // register writes
    input wire logic [scs_pkg::REG_AW-1:0] reg_addr,
    input wire logic [scs_pkg::REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    // outputs
    input wire logic main_12v_rail_en,
    input wire logic main_5v_rail_en,
    input wire logic aux_3v3_rail_en,
    input wire logic aux_12v_rail_en,
    input wire logic aux_neg12v_rail_en,
    input wire logic fail_o,
    input wire logic fail_oe,
    input wire logic system_hold_o,
    input wire logic system_hold_oe,
    input wire logic [6:0] mgmt_addr,
    input wire logic mgmt_ports_en
);
    import scs_pkg::*;
    localparam int WAIT = SAMPLE_CYCLES + 2;
    localparam int IN_WAIT = 5 * SAMPLE_CYCLES + 2;
    logic ovr_reg, rails_off;
    int prot_cnt, hot_cnt, in_cnt;
    assign rails_off = !(main_12v_rail_en | main_5v_rail_en | aux_3v3_rail_en);
    // cycles each fault has stood; override suppresses trips
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ovr_reg <= 1'b0;
            prot_cnt <= 0;
            hot_cnt <= 0;
            in_cnt <= 0;
        end else begin
            if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_SAFETY_OVERRIDE]) begin
                ovr_reg <= 1'b1;
            end
            prot_cnt <= (|{output_overvolt_guard, output_overcurrent_guard}) ? prot_cnt + 1 : 0;
            hot_cnt <= (temp_sensor_a >= TEMP_TRIP_C || temp_sensor_b >= TEMP_TRIP_C) ?
                hot_cnt + 1 : 0;
            in_cnt <= (|input_range_guard) ? in_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_rails_group: assert property (main_12v_rail_en |-> main_5v_rail_en && aux_3v3_rail_en
        && aux_12v_rail_en && aux_neg12v_rail_en) else $error("main rails not grouped");
    a_hold_fail: assert property (system_hold_oe |-> fail_oe)
        else $error("fail not tracking hold");
    a_hold_rails: assert property (system_hold_oe && $past(system_hold_oe) |-> rails_off)
        else $error("rails on during hold");
    a_prot_trip: assert property (prot_cnt > WAIT && !ovr_reg |-> rails_off && fail_oe)
        else $error("output fault not tripped");
    a_hot_trip: assert property (hot_cnt > WAIT && !ovr_reg |-> rails_off)
        else $error("overtemperature not tripped");
    a_input_shut: assert property (in_cnt > IN_WAIT |-> system_hold_oe && !mgmt_ports_en)
        else $error("input fault not shut down");
    a_addr_hold: assert property (!system_hold_oe && !$past(system_hold_oe) |->
        $stable(mgmt_addr)) else $error("address moved after capture");
    a_addr_base: assert property (mgmt_addr[6:5] == 2'b01)
        else $error("address outside base range");
    a_open_drain: assert property (fail_o == 1'b0 && system_hold_o == 1'b0)
        else $error("open-drain line driven high");
endmodule

bind scs_supervisor scs_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .input_range_guard(input_range_guard),
    .output_overvolt_guard(output_overvolt_guard),
    .output_overcurrent_guard(output_overcurrent_guard), .temp_sensor_a(temp_sensor_a),
    .temp_sensor_b(temp_sensor_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .main_12v_rail_en(main_12v_rail_en), .main_5v_rail_en(main_5v_rail_en),
    .aux_3v3_rail_en(aux_3v3_rail_en), .aux_12v_rail_en(aux_12v_rail_en),
    .aux_neg12v_rail_en(aux_neg12v_rail_en), .fail_o(fail_o), .fail_oe(fail_oe),
    .system_hold_o(system_hold_o), .system_hold_oe(system_hold_oe),
    .mgmt_addr(mgmt_addr), .mgmt_ports_en(mgmt_ports_en));

// ==== tb/scs_mgr_model.sv ====
// backplane manager model: control pins and pulled-up monitor lines
// assumes the bench sets the request levels after a rising edge
`timescale 1ns/10ps
module scs_mgr_model (
    // requests from the bench
    input wire logic on_req,
    input wire logic inh_req,
    // pins toward the supply
    output logic enable_n,
    output logic inhibit_n,
    // open-drain lines
    input wire logic fail_oe,
    input wire logic system_hold_oe,
    output logic fail_line,
    output logic hold_line
);
    // a released pin floats high through its pull-up
    assign enable_n = on_req ? 1'b0 : 1'b1;
    assign inhibit_n = inh_req ? 1'b0 : 1'b1;
    assign fail_line = fail_oe ? 1'b0 : 1'b1;
    assign hold_line = system_hold_oe ? 1'b0 : 1'b1;
endmodule

// ==== tb/tb.sv ====
// bench for the supply supervisor: pins, faults and register port
// assumes short sample, retry and crank parameters to keep the run brief
`timescale 1ns/10ps
module tb;
    import scs_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic on_req = 1'b0, inh_req = 1'b0;
    logic [5:0] slot_n = 6'h1C;
    logic [1:0] in_guard = 2'h0;
    logic [4:0] ov_guard = 5'h00, oc_guard = 5'h00;
    logic dip = 1'b0, crank = 1'b0;
    logic [7:0] temp_a = 8'h28, temp_b = 8'h3C;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_rdata, reg_wdata = 16'h0000, edge_p0 = 16'h0123, edge_p1 = 16'hFF85;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic enable_n, inhibit_n, fail_line, hold_line, fail_oe, system_hold_oe;
    logic main_12v_rail_en, main_5v_rail_en, aux_3v3_rail_en, aux_12v_rail_en;
    logic aux_neg12v_rail_en, power_limit_500w, mgmt_ports_en;
    logic [6:0] mgmt_addr;
    int error_cnt = 0, num_checks = 0;
    scs_mgr_model u_mgr (.on_req(on_req), .inh_req(inh_req), .enable_n(enable_n),
        .inhibit_n(inhibit_n), .fail_oe(fail_oe), .system_hold_oe(system_hold_oe),
        .fail_line(fail_line), .hold_line(hold_line));
    scs_supervisor #(.SAMPLE_CYCLES(20), .RETRY_TICKS(4), .CRANK_DIP_TICKS(3),
        .CRANK_FULL_TICKS(6)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .enable_n(enable_n), .inhibit_n(inhibit_n), .slot_addr_bit0_n(slot_n[0]),
        .slot_addr_bit1_n(slot_n[1]), .slot_addr_bit2_n(slot_n[2]),
        .slot_addr_bit3_n(slot_n[3]), .slot_addr_bit4_n(slot_n[4]),
        .slot_addr_parity_n(slot_n[5]), .input_range_guard(in_guard),
        .output_overvolt_guard(ov_guard), .output_overcurrent_guard(oc_guard),
        .starter_engage_dip(dip), .crank_low_input(crank), .temp_sensor_a(temp_a),
        .temp_sensor_b(temp_b), .edge_temp_p0(edge_p0), .edge_temp_p1(edge_p1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .main_12v_rail_en(main_12v_rail_en),
        .main_5v_rail_en(main_5v_rail_en), .aux_3v3_rail_en(aux_3v3_rail_en),
        .aux_12v_rail_en(aux_12v_rail_en), .aux_neg12v_rail_en(aux_neg12v_rail_en),
        .power_limit_500w(power_limit_500w), .fail_o(), .fail_oe(fail_oe),
        .system_hold_o(), .system_hold_oe(system_hold_oe), .mgmt_addr(mgmt_addr),
        .mgmt_ports_en(mgmt_ports_en));
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return main_12v_rail_en;
            1: return aux_3v3_rail_en;
            2: return hold_line;
            3: return mgmt_ports_en;
            default: return power_limit_500w;
        endcase
    endfunction
    // bounded wait for a level; running out ends the run
    task automatic wt(input int s, input logic v, input int n);
        for (int i = 0; i < n && sig(s) !== v; i++) begin
            cyc(1);
        end
        chk(sig(s), v);
        if (sig(s) !== v) print_verdict();
    endtask
    initial begin
        cyc(10);
        sys_rst <= 1'b0;
        chk(hold_line, 1'b0);
        chk(fail_line, 1'b0);
        wt(2, 1'b1, 12000);
        chk(mgmt_addr, 7'h23);
        rd(REG_HW_ADDR, 16'h0023);
        slot_n <= 6'h18;
        cyc(40);
        chk(mgmt_addr, 7'h23);
        chk(aux_3v3_rail_en, 1'b0);
        on_req <= 1'b1;
        wt(0, 1'b1, 800);
        chk({main_5v_rail_en, aux_3v3_rail_en, aux_12v_rail_en, aux_neg12v_rail_en}, 4'hF);
        on_req <= 1'b0;
        cyc(200);
        on_req <= 1'b1;
        cyc(700);
        chk(main_12v_rail_en, 1'b1);
        inh_req <= 1'b1;
        cyc(200);
        on_req <= 1'b0;
        wt(0, 1'b0, 400);
        chk(aux_3v3_rail_en, 1'b1);
        cyc(250);
        chk(aux_3v3_rail_en, 1'b1);
        wt(1, 1'b0, 300);
        on_req <= 1'b1;
        inh_req <= 1'b0;
        wt(0, 1'b1, 1100);
        for (int k = 0; k < 2; k++) begin
            oc_guard <= k ? 5'h00 : 5'h04;
            ov_guard <= k ? 5'h10 : 5'h00;
            wt(0, 1'b0, 60);
            cyc(30);
            chk({main_12v_rail_en, fail_line}, 2'b00);
            oc_guard <= 5'h00;
            ov_guard <= 5'h00;
            wt(0, 1'b1, 700);
            chk(fail_line, 1'b1);
        end
        rd(REG_HOT_TEMP, 16'h003C);
        rd(REG_EDGE_P1, 16'hFF85);
        rd(REG_EDGE_P0, 16'h0123);
        wr(REG_STATUS, 16'h0020);
        rd(REG_STATUS, 16'h0022);
        temp_a <= 8'h55;
        cyc(50);
        rd(REG_STATUS, 16'h0002);
        rd(REG_HOT_TEMP, 16'h0055);
        temp_a <= 8'h5F;
        wt(0, 1'b0, 60);
        cyc(30);
        temp_a <= 8'h4C;
        cyc(100);
        chk(main_12v_rail_en, 1'b0);
        temp_a <= 8'h4B;
        wt(0, 1'b1, 800);
        dip <= 1'b1;
        wt(4, 1'b1, 60);
        wt(0, 1'b0, 200);
        dip <= 1'b0;
        wt(0, 1'b1, 800);
        crank <= 1'b1;
        wt(0, 1'b0, 200);
        crank <= 1'b0;
        wt(0, 1'b1, 100);
        wr(REG_STATUS, 16'h0018);
        on_req <= 1'b0;
        cyc(800);
        chk(main_12v_rail_en, 1'b1);
        wr(REG_STATUS, 16'h0010);
        wt(0, 1'b0, 700);
        chk(aux_3v3_rail_en, 1'b1);
        wr(REG_STATUS, 16'h0000);
        wt(1, 1'b0, 700);
        in_guard <= 2'h1;
        wt(3, 1'b0, 200);
        chk(hold_line, 1'b0);
        cyc(40);
        in_guard <= 2'h0;
        wt(2, 1'b1, 12000);
        chk(mgmt_addr, 7'h20);
        print_verdict();
    end
endmodule
